// ==== rtl/dma_chan_pkg.sv ====
// Purpose: shared constants and types for the dma channel control and status block
// Assumes: 8-bit register port, one channel per instance
// Notes: offsets are register byte offsets within the channel window
package dma_chan_pkg;
	// register offsets
	localparam logic [7:0] OFF_STATE = 8'h00;
	localparam logic [7:0] OFF_ERROR = 8'h01;
	localparam logic [7:0] OFF_DEVICE = 8'h04;
	localparam logic [7:0] OFF_SETUP = 8'h05;
	localparam logic [7:0] OFF_STEP = 8'h06;
	localparam logic [7:0] OFF_RUN = 8'h07;

	// channel_state_flags bit positions
	localparam int B_OP_COMPLETE = 7;
	localparam int B_BLOCK_COMPLETE = 6;
	localparam int B_PERIPH_END = 5;
	localparam int B_ERROR = 4;
	localparam int B_ACTIVE = 3;
	localparam int B_LINE_FALL = 1;
	localparam int B_LINE_LEVEL = 0;

	// channel_run_control bit positions
	localparam int B_START = 7;
	localparam int B_CONTINUE = 6;
	localparam int B_HALT = 5;
	localparam int B_SOFT_ABORT = 4;
	localparam int B_IRQ_ENABLE = 3;

	// transfer_operation_setup fields
	localparam int B_DIR = 7;
	localparam int F_SIZE_LO = 4;
	localparam int F_CHAIN_LO = 2;
	localparam int F_REQ_LO = 0;
	// address_step_setup fields
	localparam int F_MEM_STEP_LO = 2;
	localparam int F_DEV_STEP_LO = 0;

	// field codes
	localparam logic [1:0] LINE_STATUS = 2'h0;
	localparam logic [1:0] LINE_STATUS_IRQ = 2'h1;
	localparam logic [1:0] LINE_START_PULSE = 2'h2;
	localparam logic [1:0] LINE_ABORT_IN = 2'h3;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [1:0] SIZE_RSVD = 2'h3;
	localparam logic [1:0] CHAIN_NONE = 2'h0;
	localparam logic [1:0] CHAIN_RSVD = 2'h1;
	localparam logic [1:0] REQ_AUTO_LIMITED = 2'h0;
	localparam logic [1:0] REQ_AUTO_FULL = 2'h1;
	localparam logic [1:0] REQ_EXTERNAL = 2'h2;
	localparam logic [1:0] REQ_FIRST_AUTO = 2'h3;
	localparam logic [1:0] STEP_HOLD = 2'h0;
	localparam logic [1:0] STEP_UP = 2'h1;
	localparam logic [1:0] STEP_DOWN = 2'h2;
	localparam logic [1:0] STEP_RSVD = 2'h3;

	// error codes
	localparam logic [4:0] ERR_NONE = 5'h00;
	localparam logic [4:0] ERR_CONFIG = 5'h01;
	localparam logic [4:0] ERR_TIMING = 5'h02;
	localparam logic [4:0] ERR_COUNT_MEM = 5'h0D;
	localparam logic [4:0] ERR_EXT_ABORT = 5'h10;
	localparam logic [4:0] ERR_SOFT_ABORT = 5'h11;

	// reset values
	localparam logic [7:0] RESET_REG = 8'h00;
	// default gap between rate-limited automatic requests, in clocks
	localparam int RATE_GAP_CLOCKS = 32;

	typedef enum {ST_IDLE, ST_RUN} chan_state_t;

	// one operand on its way to or from memory
	typedef struct packed {
		logic [23:0] addr;
		logic [31:0] data;
		logic [1:0] size;
	} mem_beat_t;
endpackage

// ==== rtl/sync_two_flop.sv ====
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_sys
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module sync_two_flop #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_sys,
	input wire logic rst_sync_b,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_sync
);
	logic [W-1:0] stage1;

	// metastability guard
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			stage1 <= INIT;
			pin_sync <= INIT;
		end else begin
			stage1 <= pin_in;
			pin_sync <= stage1;
		end
	end
endmodule

// ==== rtl/two_entry_buffer.sv ====
// Purpose: two-entry valid/ready buffer in the operand path
// Assumes: single clock, same-cycle push and pop allowed
// Notes: in_ready drops only when both entries hold data
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int W = 58
) (
	input wire logic clk_sys,
	input wire logic rst_sync_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] slot [2];
	logic rd_ptr;
	logic wr_ptr;
	logic [1:0] fill;
	logic push;
	logic pop;

	assign in_ready = (fill != 2'h2);
	assign out_valid = (fill != 2'h0);
	assign out_data = slot[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage and pointers
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			fill <= 2'h0;
			slot[0] <= '0;
			slot[1] <= '0;
		end else begin
			if (push) begin
				slot[wr_ptr] <= in_data;
				wr_ptr <= !wr_ptr;
			end
			if (pop)
				rd_ptr <= !rd_ptr;
			if (push && !pop)
				fill <= fill + 2'h1;
			else if (pop && !push)
				fill <= fill - 2'h1;
		end
	end
endmodule

// ==== rtl/dma_channel_control_status.sv ====
// Purpose: control and status logic of one dma channel
// Assumes: 25 MHz clk_sys; peripheral pins asynchronous; 8-bit register port
// Notes: address and count start values come in on ports, not registers
// Notes on behaviour
// - line function: 00 status, 01 status with irq, 10 start pulse, 11 abort
// - line level bit mirrors the control line level and ignores writes
// - falling edge on the control line sets the line fall flag
// - direction 0 moves memory to peripheral, 1 peripheral to memory
// - operand size 00 byte, 01 word, 10 long; 11 reserved
// - chaining 00 none, 10 array, 11 linked; 01 reserved
// - requests: 00 paced auto, 01 full-rate auto, 10 external, 11 first auto
// - memory address holds, counts up or counts down per operand
// - device address steps likewise, only in memory-to-memory transfers
// - writing start as one activates the channel at once
// - start and continue bits cannot be cleared by writing zero
// - soft abort ends the operation and clears start and continue
// - halt suspends the channel; clearing halt resumes where it stopped
// - irq enable gates every channel interrupt
// - status flags set by hardware, cleared by writing one or reset
// - op complete set on every termination; cleared before next start
// - block complete on unchained continue; re-continue while set is timing error
// - error flag set with cause logged; clearing it clears the cause
// - active flag set from start until termination; ignores writes
// - periph end flag set when the peripheral ends the operation
// - counter decrements per operand; zero with no chain left completes
// - irq when enabled and op complete, block complete or irq-line fall
// - error codes: config, timing, count, external and soft abort
`timescale 1ns/1ps
module dma_channel_control_status #(
	parameter int COUNT_W = 16,
	parameter int ADDR_W = 24,
	parameter int RATE_GAP = dma_chan_pkg::RATE_GAP_CLOCKS
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic reg_cs,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic periph_ctrl_line_in,
	output logic periph_ctrl_line_out,
	output logic periph_ctrl_line_oe,
	input wire logic periph_req_b,
	input wire logic periph_done_b,
	input wire logic [7:0] periph_rdata,
	output logic periph_ack_b,
	output logic [7:0] periph_wdata,
	input wire logic mem_in_valid,
	output logic mem_in_ready,
	input wire logic [31:0] mem_in_data,
	output logic mem_out_valid,
	input wire logic mem_out_ready,
	output dma_chan_pkg::mem_beat_t mem_out,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [ADDR_W-1:0] dev_addr,
	output logic [COUNT_W-1:0] xfer_counter,
	input wire logic [COUNT_W-1:0] count_init,
	input wire logic [ADDR_W-1:0] mem_addr_init,
	input wire logic [ADDR_W-1:0] dev_addr_init,
	input wire logic [COUNT_W-1:0] base_count,
	input wire logic [ADDR_W-1:0] base_addr,
	input wire logic chain_last,
	output logic irq_req
);
	logic rst_meta_b;
	logic rst_sync_b;
	dma_chan_pkg::chan_state_t state;
	logic [7:0] setup_reg;
	logic [7:0] step_reg;
	logic [1:0] line_func;
	logic start_flag, continue_flag, halt_flag, soft_abort_flag, irq_enable;
	logic op_complete_flag, block_complete_flag, periph_end_flag, error_flag;
	logic line_fall_flag;
	logic [4:0] error_cause_reg;
	logic line_sync, line_prev, req_sync_b, req_prev_b, done_sync_b, done_prev_b;
	logic [7:0] rdata_sync;
	logic line_fall, req_fall, done_fall, req_pending, first_done;
	logic [$clog2(RATE_GAP+1)-1:0] gap_cnt;
	logic wr_any, wr_state, wr_run, start_req, start_bad, run_ok;
	logic abort_soft, abort_ext, periph_end, want, launch, block_end;
	logic cont_taken, chain_next, cont_clash, finish_ok, terminate, err_event;
	logic [4:0] err_code;
	logic dir;
	logic [1:0] size_sel, chain_sel, req_sel, mem_step_sel, dev_step_sel;
	logic [ADDR_W-1:0] step_amt;
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
	dma_chan_pkg::mem_beat_t buf_in_beat, buf_out_beat;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// pins into the clock domain; idle level of the active-low lines is high
	sync_two_flop #(.W(3), .INIT(3'h7)) u_sync_ctl (
		.clk_sys(clk_sys),
		.rst_sync_b(rst_sync_b),
		.pin_in({periph_ctrl_line_in, periph_req_b, periph_done_b}),
		.pin_sync({line_sync, req_sync_b, done_sync_b})
	);
	sync_two_flop #(.W(8), .INIT(8'h00)) u_sync_data (
		.clk_sys(clk_sys),
		.rst_sync_b(rst_sync_b),
		.pin_in(periph_rdata),
		.pin_sync(rdata_sync)
	);

	// edge history of synchronised lines
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			line_prev <= 1'b1;
			req_prev_b <= 1'b1;
			done_prev_b <= 1'b1;
		end else begin
			line_prev <= line_sync;
			req_prev_b <= req_sync_b;
			done_prev_b <= done_sync_b;
		end
	end
	assign line_fall = line_prev && !line_sync;
	assign req_fall = req_prev_b && !req_sync_b;
	assign done_fall = done_prev_b && !done_sync_b;

	// field views
	assign dir = setup_reg[dma_chan_pkg::B_DIR];
	assign size_sel = setup_reg[dma_chan_pkg::F_SIZE_LO +: 2];
	assign chain_sel = setup_reg[dma_chan_pkg::F_CHAIN_LO +: 2];
	assign req_sel = setup_reg[dma_chan_pkg::F_REQ_LO +: 2];
	assign mem_step_sel = step_reg[dma_chan_pkg::F_MEM_STEP_LO +: 2];
	assign dev_step_sel = step_reg[dma_chan_pkg::F_DEV_STEP_LO +: 2];

	// register writes and the events they raise
	assign wr_any = reg_cs && reg_we;
	assign wr_state = wr_any && (reg_addr == dma_chan_pkg::OFF_STATE);
	assign wr_run = wr_any && (reg_addr == dma_chan_pkg::OFF_RUN);
	assign start_req = wr_run && reg_wdata[dma_chan_pkg::B_START] && (state == dma_chan_pkg::ST_IDLE);
	// reserved codes are refused at start, not silently run
	assign start_bad = (size_sel == dma_chan_pkg::SIZE_RSVD)
		|| (chain_sel == dma_chan_pkg::CHAIN_RSVD)
		|| (mem_step_sel == dma_chan_pkg::STEP_RSVD)
		|| (dev_step_sel == dma_chan_pkg::STEP_RSVD)
		|| op_complete_flag
		|| (count_init == '0);
	assign run_ok = start_req && !start_bad;
	assign abort_soft = wr_run && reg_wdata[dma_chan_pkg::B_SOFT_ABORT];
	assign abort_ext = (line_func == dma_chan_pkg::LINE_ABORT_IN) && line_fall;
	assign periph_end = done_fall;

	// request generation per operand
	always_comb begin
		case (req_sel)
			dma_chan_pkg::REQ_AUTO_LIMITED: want = (gap_cnt == '0);
			dma_chan_pkg::REQ_AUTO_FULL: want = 1'b1;
			dma_chan_pkg::REQ_EXTERNAL: want = req_pending;
			dma_chan_pkg::REQ_FIRST_AUTO: want = !first_done || req_pending;
			default: want = 1'b0;
		endcase
	end
	// halt only withholds launches, so counter and addresses stay where they stopped
	assign launch = (state == dma_chan_pkg::ST_RUN) && !halt_flag && !abort_soft && want
		&& (dir ? buf_in_ready : buf_out_valid);
	assign block_end = launch && (xfer_counter == COUNT_W'(1));
	assign cont_taken = block_end && (chain_sel == dma_chan_pkg::CHAIN_NONE) && continue_flag;
	assign chain_next = block_end && (chain_sel != dma_chan_pkg::CHAIN_NONE) && !chain_last;
	assign cont_clash = wr_run && reg_wdata[dma_chan_pkg::B_CONTINUE]
		&& (state == dma_chan_pkg::ST_RUN) && block_complete_flag;
	assign finish_ok = block_end && !cont_taken && !chain_next;

	// termination and its error cause, soft abort first
	always_comb begin
		err_event = 1'b1;
		err_code = dma_chan_pkg::ERR_NONE;
		if (abort_soft && (state == dma_chan_pkg::ST_RUN || start_req))
			err_code = dma_chan_pkg::ERR_SOFT_ABORT;
		else if (start_req && start_bad) begin
			if (op_complete_flag || block_complete_flag)
				err_code = dma_chan_pkg::ERR_TIMING;
			else if (count_init == '0)
				err_code = dma_chan_pkg::ERR_COUNT_MEM;
			else
				err_code = dma_chan_pkg::ERR_CONFIG;
		end else if (state == dma_chan_pkg::ST_RUN && abort_ext)
			err_code = dma_chan_pkg::ERR_EXT_ABORT;
		else if (cont_clash)
			err_code = dma_chan_pkg::ERR_TIMING;
		else
			err_event = 1'b0;
	end
	assign terminate = err_event
		|| ((state == dma_chan_pkg::ST_RUN) && (periph_end || finish_ok));

	// channel state
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b)
			state <= dma_chan_pkg::ST_IDLE;
		else if (terminate)
			state <= dma_chan_pkg::ST_IDLE;
		else if (run_ok)
			state <= dma_chan_pkg::ST_RUN;
	end

	// setup registers written by software
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			setup_reg <= dma_chan_pkg::RESET_REG;
			step_reg <= dma_chan_pkg::RESET_REG;
			line_func <= dma_chan_pkg::LINE_STATUS;
		end else if (wr_any) begin
			if (reg_addr == dma_chan_pkg::OFF_SETUP)
				setup_reg <= reg_wdata & 8'hBF;
			if (reg_addr == dma_chan_pkg::OFF_STEP)
				step_reg <= reg_wdata & 8'h0F;
			if (reg_addr == dma_chan_pkg::OFF_DEVICE)
				line_func <= reg_wdata[1:0];
		end
	end

	// run control bits; zero writes never clear start or continue
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			start_flag <= 1'b0;
			continue_flag <= 1'b0;
			halt_flag <= 1'b0;
			soft_abort_flag <= 1'b0;
			irq_enable <= 1'b0;
		end else begin
			if (wr_run) begin
				halt_flag <= reg_wdata[dma_chan_pkg::B_HALT];
				soft_abort_flag <= reg_wdata[dma_chan_pkg::B_SOFT_ABORT];
				irq_enable <= reg_wdata[dma_chan_pkg::B_IRQ_ENABLE];
			end
			if (terminate) begin
				start_flag <= 1'b0;
				continue_flag <= 1'b0;
			end else begin
				if (run_ok)
					start_flag <= 1'b1;
				if (cont_taken)
					continue_flag <= 1'b0;
				else if (wr_run && reg_wdata[dma_chan_pkg::B_CONTINUE]
					&& (run_ok || state == dma_chan_pkg::ST_RUN))
					continue_flag <= 1'b1;
			end
		end
	end

	// sticky status: a set in the same cycle as a one-write wins
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			op_complete_flag <= 1'b0;
			block_complete_flag <= 1'b0;
			periph_end_flag <= 1'b0;
			error_flag <= 1'b0;
			line_fall_flag <= 1'b0;
			error_cause_reg <= dma_chan_pkg::ERR_NONE;
		end else begin
			if (terminate)
				op_complete_flag <= 1'b1;
			else if (wr_state && reg_wdata[dma_chan_pkg::B_OP_COMPLETE])
				op_complete_flag <= 1'b0;
			if (cont_taken)
				block_complete_flag <= 1'b1;
			else if (wr_state && reg_wdata[dma_chan_pkg::B_BLOCK_COMPLETE])
				block_complete_flag <= 1'b0;
			if (state == dma_chan_pkg::ST_RUN && periph_end && !err_event)
				periph_end_flag <= 1'b1;
			else if (wr_state && reg_wdata[dma_chan_pkg::B_PERIPH_END])
				periph_end_flag <= 1'b0;
			if (line_fall)
				line_fall_flag <= 1'b1;
			else if (wr_state && reg_wdata[dma_chan_pkg::B_LINE_FALL])
				line_fall_flag <= 1'b0;
			if (err_event) begin
				error_flag <= 1'b1;
				error_cause_reg <= err_code;
			end else if (wr_state && reg_wdata[dma_chan_pkg::B_ERROR]) begin
				error_flag <= 1'b0;
				error_cause_reg <= dma_chan_pkg::ERR_NONE;
			end
		end
	end

	// request pacing and external request capture
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			gap_cnt <= '0;
			req_pending <= 1'b0;
			first_done <= 1'b0;
		end else begin
			if (launch)
				gap_cnt <= ($clog2(RATE_GAP+1))'(RATE_GAP - 1);
			else if (gap_cnt != '0)
				gap_cnt <= gap_cnt - 1'b1;
			// a fall in the launch cycle is kept for the next operand
			if (req_fall)
				req_pending <= 1'b1;
			else if (launch)
				req_pending <= 1'b0;
			if (run_ok)
				first_done <= 1'b0;
			else if (launch)
				first_done <= 1'b1;
		end
	end

	// address step by operand size
	always_comb begin
		case (size_sel)
			dma_chan_pkg::SIZE_WORD: step_amt = ADDR_W'(2);
			dma_chan_pkg::SIZE_LONG: step_amt = ADDR_W'(4);
			default: step_amt = ADDR_W'(1);
		endcase
	end

	// counter and address sequencing
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			xfer_counter <= '0;
			mem_addr <= '0;
			dev_addr <= '0;
		end else if (run_ok) begin
			xfer_counter <= count_init;
			mem_addr <= mem_addr_init;
			dev_addr <= dev_addr_init;
		end else if (cont_taken || chain_next) begin
			xfer_counter <= base_count; // next block takes over
			mem_addr <= base_addr;
		end else if (launch) begin
			xfer_counter <= xfer_counter - 1'b1;
			if (mem_step_sel == dma_chan_pkg::STEP_UP)
				mem_addr <= mem_addr + step_amt;
			else if (mem_step_sel == dma_chan_pkg::STEP_DOWN)
				mem_addr <= mem_addr - step_amt;
			// device address moves only in memory-to-memory mode
			if (req_sel == dma_chan_pkg::REQ_AUTO_LIMITED
				|| req_sel == dma_chan_pkg::REQ_AUTO_FULL) begin
				if (dev_step_sel == dma_chan_pkg::STEP_UP)
					dev_addr <= dev_addr + step_amt;
				else if (dev_step_sel == dma_chan_pkg::STEP_DOWN)
					dev_addr <= dev_addr - step_amt;
			end
		end
	end

	// operand path through the buffer; direction picks filler and drainer
	always_comb begin
		buf_in_beat.addr = mem_addr;
		buf_in_beat.size = size_sel;
		if (dir) begin
			buf_in_beat.data = {24'h000000, rdata_sync};
			buf_in_valid = launch;
		end else begin
			buf_in_beat.data = mem_in_data;
			buf_in_valid = mem_in_valid && (state == dma_chan_pkg::ST_RUN);
		end
	end
	assign mem_in_ready = !dir && buf_in_ready && (state == dma_chan_pkg::ST_RUN);
	assign buf_out_ready = dir ? mem_out_ready : launch;
	assign mem_out_valid = dir && buf_out_valid;
	assign mem_out = buf_out_beat;

	two_entry_buffer #(.W($bits(dma_chan_pkg::mem_beat_t))) u_buf (
		.clk_sys(clk_sys),
		.rst_sync_b(rst_sync_b),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_beat),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_beat)
	);

	// peripheral acknowledge, start pulse and line drive
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			periph_ack_b <= 1'b1;
			periph_wdata <= 8'h00;
			periph_ctrl_line_out <= 1'b1;
			periph_ctrl_line_oe <= 1'b0;
		end else begin
			periph_ack_b <= !launch;
			if (launch && !dir)
				periph_wdata <= buf_out_beat.data[7:0];
			// a sub-cycle pulse is not possible, so the low pulse is one clock
			periph_ctrl_line_out <= !(run_ok && line_func == dma_chan_pkg::LINE_START_PULSE);
			periph_ctrl_line_oe <= (line_func == dma_chan_pkg::LINE_START_PULSE);
		end
	end

	// interrupt request, gated by enable
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b)
			irq_req <= 1'b0;
		else
			irq_req <= irq_enable && (op_complete_flag || block_complete_flag
				|| (line_fall_flag && line_func == dma_chan_pkg::LINE_STATUS_IRQ));
	end

	// read data, one clock after the read
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b)
			reg_rdata <= 8'h00;
		else if (reg_cs && !reg_we) begin
			case (reg_addr)
				dma_chan_pkg::OFF_STATE: reg_rdata <= {op_complete_flag, block_complete_flag,
					periph_end_flag, error_flag, state == dma_chan_pkg::ST_RUN, 1'b0,
					line_fall_flag, line_sync};
				dma_chan_pkg::OFF_ERROR: reg_rdata <= {3'h0, error_cause_reg};
				dma_chan_pkg::OFF_DEVICE: reg_rdata <= {6'h00, line_func};
				dma_chan_pkg::OFF_SETUP: reg_rdata <= setup_reg;
				dma_chan_pkg::OFF_STEP: reg_rdata <= step_reg;
				dma_chan_pkg::OFF_RUN: reg_rdata <= {start_flag, continue_flag, halt_flag,
					soft_abort_flag, irq_enable, 3'h0};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// ==== testbench/dma_channel_props.sv ====
// Purpose: port properties of the dma channel block
// Assumes: bound onto dma_channel_control_status
// Notes: rst_b is async, active low
`timescale 1ns/1ps
module dma_channel_props (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic reg_cs,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic periph_ctrl_line_out,
	input wire logic periph_ctrl_line_oe,
	input wire logic periph_ack_b,
	input wire logic mem_out_valid,
	input wire logic mem_out_ready,
	input wire logic [15:0] xfer_counter,
	input wire logic irq_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// start pulse output enabled within two clocks once the line function asks for it
	a_oe_on_func: assert property (reg_cs && reg_we && reg_addr == 8'h04
		&& reg_wdata[1:0] == 2'h2 |-> ##[1:2] periph_ctrl_line_oe) else $error("oe late");
	a_line_idle_high: assert property (!periph_ctrl_line_oe |-> periph_ctrl_line_out)
		else $error("line low undriven");
	a_pulse_one_clk: assert property ($fell(periph_ctrl_line_out)
		|=> $rose(periph_ctrl_line_out)) else $error("pulse too long");
	// back-to-back operands keep ack low, so tie each ack cycle to one count step
	a_ack_steps_count: assert property (!periph_ack_b |-> $past(xfer_counter) == 16'h0001
		|| xfer_counter == $past(xfer_counter) - 16'h0001) else $error("ack without count step");
	a_beat_holds: assert property (mem_out_valid && !mem_out_ready |=> mem_out_valid)
		else $error("beat dropped");
	// irq enable cleared kills the request two clocks on at most
	a_irq_gate_off: assert property (reg_cs && reg_we && reg_addr == 8'h07
		&& !reg_wdata[3] |-> ##2 !irq_req) else $error("irq not gated");
	a_rdata_holds: assert property (!(reg_cs && !reg_we) |=> $stable(reg_rdata))
		else $error("rdata moved");
	a_run_rsvd_zero: assert property (reg_cs && !reg_we && reg_addr == 8'h07
		|=> reg_rdata[2:0] == 3'h0) else $error("reserved bits set");
endmodule
bind dma_channel_control_status dma_channel_props i_props (.clk_sys, .rst_b, .reg_cs, .reg_we,
	.reg_addr, .reg_wdata, .reg_rdata, .periph_ctrl_line_out, .periph_ctrl_line_oe, .periph_ack_b,
	.mem_out_valid, .mem_out_ready, .xfer_counter, .irq_req);

// ==== testbench/periph_model.sv ====
// Purpose: talker/listener peripheral on the request/ack side
// Assumes: one request outstanding until acked
// Notes: line has a pull-up; the block drives it when oe is high
`timescale 1ns/1ps
module periph_model (
	input wire logic clk_sys,
	input wire logic req_en,
	input wire logic line_lvl,
	input wire logic end_now,
	input wire logic periph_ack_b,
	input wire logic periph_ctrl_line_out,
	input wire logic periph_ctrl_line_oe,
	output logic periph_ctrl_line_in,
	output logic periph_req_b,
	output logic periph_done_b,
	output logic [7:0] periph_rdata
);
	logic waiting;
	// wired line level
	assign periph_ctrl_line_in = periph_ctrl_line_oe ? periph_ctrl_line_out : line_lvl;
	initial begin
		waiting = 1'b0;
		periph_req_b = 1'b1;
		periph_done_b = 1'b1;
		periph_rdata = 8'h00;
	end
	// one-clock request, next byte only after ack
	always @(negedge clk_sys) begin
		periph_done_b <= !end_now;
		periph_req_b <= 1'b1;
		if (!periph_ack_b) begin
			waiting <= 1'b0;
			periph_rdata <= periph_rdata + 8'h01;
		end else if (req_en && !waiting) begin
			periph_req_b <= 1'b0;
			waiting <= 1'b1;
		end
	end
endmodule

// ==== testbench/dma_channel_control_status_test.sv ====
// Purpose: register-level tests of the dma channel block
// Assumes: inputs change on falling edges
// Notes: RATE_GAP shortened to 2
`timescale 1ns/1ps
module dma_channel_control_status_test;
	logic clk_sys = 1'b0, rst_b = 1'b0, reg_cs = 1'b0, reg_we = 1'b0, mem_in_valid = 1'b0;
	logic mem_out_ready = 1'b1, chain_last = 1'b0, req_en = 1'b0, line_lvl = 1'b1, end_now = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, periph_rdata, periph_wdata, v;
	logic periph_ctrl_line_in, periph_ctrl_line_out, periph_ctrl_line_oe, periph_req_b;
	logic periph_done_b, periph_ack_b, mem_in_ready, mem_out_valid, irq_req;
	logic [31:0] mem_in_data = 32'h00000000;
	logic [15:0] count_init = 16'h0003, base_count = 16'h0000, xfer_counter;
	logic [23:0] mem_addr_init = 24'h000100, dev_addr_init = 24'h000000;
	logic [23:0] base_addr = 24'h000000, mem_addr;
	dma_chan_pkg::mem_beat_t mem_out;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	always #20 clk_sys = !clk_sys;
	dma_channel_control_status #(.RATE_GAP(2)) i_dut (.clk_sys, .rst_b, .reg_cs, .reg_we,
		.reg_addr, .reg_wdata, .reg_rdata, .periph_ctrl_line_in, .periph_ctrl_line_out,
		.periph_ctrl_line_oe, .periph_req_b, .periph_done_b, .periph_rdata, .periph_ack_b,
		.periph_wdata, .mem_in_valid, .mem_in_ready, .mem_in_data, .mem_out_valid,
		.mem_out_ready, .mem_out, .mem_addr, .dev_addr(), .xfer_counter, .count_init,
		.mem_addr_init, .dev_addr_init, .base_count, .base_addr, .chain_last, .irq_req);
	periph_model i_periph (.clk_sys, .req_en, .line_lvl, .end_now, .periph_ack_b,
		.periph_ctrl_line_out, .periph_ctrl_line_oe, .periph_ctrl_line_in, .periph_req_b,
		.periph_done_b, .periph_rdata);
	task automatic report_and_stop;
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// one access plus an idle clock, so strobes never toggle twice in a step
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		reg_cs <= 1'b1;
		reg_we <= w;
		reg_addr <= a;
		reg_wdata <= d;
		tick(1);
		reg_cs <= 1'b0;
		if (!w) chk(reg_rdata, d);
		tick(1);
	endtask
	task automatic wait_cnt(input logic [15:0] c);
		for (int k = 0; k < 300 && xfer_counter !== c; k++) tick(1);
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		tick(12);
		rst_b <= 1'b1;
		tick(4);
		acc(0, 8'h00, 8'h01);
		acc(0, 8'h02, 8'h00);
		line_lvl <= 1'b0;
		tick(4);
		acc(0, 8'h00, 8'h02);
		acc(1, 8'h00, 8'h01);
		acc(0, 8'h00, 8'h02);
		acc(1, 8'h04, 8'h01);
		acc(1, 8'h07, 8'h08);
		chk(irq_req, 1'b1);
		acc(1, 8'h07, 8'h00);
		chk(irq_req, 1'b0);
		acc(1, 8'h00, 8'h02);
		acc(0, 8'h00, 8'h00);
		acc(1, 8'h04, 8'h00);
		line_lvl <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			v = {i[0], 1'b0, i[1:0], i[1:0], i[1:0]};
			acc(1, 8'h05, v | 8'h40);
			acc(0, 8'h05, v);
			acc(1, 8'h06, {4'h0, i[1:0], i[1:0]});
			acc(0, 8'h06, {4'h0, i[1:0], i[1:0]});
		end
		// peripheral to memory with the memory side stalled
		acc(1, 8'h05, 8'h82);
		acc(1, 8'h06, 8'h04);
		mem_out_ready <= 1'b0;
		acc(1, 8'h07, 8'h80);
		acc(0, 8'h00, 8'h09);
		req_en <= 1'b1;
		wait_cnt(16'h0001);
		tick(40);
		chk(xfer_counter, 16'h0001);
		chk(mem_out.addr, 24'h000100);
		chk(mem_out.data[7:0], 8'h00);
		mem_out_ready <= 1'b1;
		wait_cnt(16'h0000);
		tick(4);
		req_en <= 1'b0;
		chk(mem_addr, 24'h000103);
		acc(0, 8'h00, 8'h81);
		acc(1, 8'h07, 8'h80);
		acc(0, 8'h00, 8'h91);
		acc(0, 8'h01, 8'h02);
		acc(1, 8'h00, 8'h10);
		acc(0, 8'h01, 8'h00);
		acc(1, 8'h00, 8'h80);
		// halted start, then resume
		count_init <= 16'h0005;
		acc(1, 8'h05, 8'h81);
		acc(1, 8'h07, 8'hA0);
		tick(8);
		chk(xfer_counter, 16'h0005);
		acc(1, 8'h07, 8'h00);
		wait_cnt(16'h0000);
		tick(4);
		acc(0, 8'h00, 8'h81);
		acc(1, 8'h00, 8'h80);
		// start pulse on the line, then peripheral end
		chain_last <= 1'b1;
		acc(1, 8'h04, 8'h02);
		acc(1, 8'h05, 8'h82);
		acc(1, 8'h07, 8'h80);
		acc(1, 8'h07, 8'h00);
		acc(0, 8'h07, 8'h80);
		end_now <= 1'b1;
		tick(4);
		end_now <= 1'b0;
		tick(4);
		acc(0, 8'h00, 8'hA3);
		acc(1, 8'h00, 8'hA2);
		acc(1, 8'h07, 8'h80);
		acc(1, 8'h07, 8'h10);
		acc(0, 8'h07, 8'h10);
		acc(0, 8'h00, 8'h93);
		acc(0, 8'h01, 8'h11);
		// memory to peripheral, two blocks joined by continue
		count_init <= 16'h0002;
		base_count <= 16'h0002;
		mem_in_data <= 32'h000000A5;
		mem_in_valid <= 1'b1;
		acc(1, 8'h00, 8'h92);
		acc(1, 8'h05, 8'h01);
		acc(1, 8'h07, 8'hC0);
		tick(12);
		chk(periph_wdata, 8'hA5);
		acc(0, 8'h00, 8'hC3);
		report_and_stop();
	end
endmodule
